// File: core/fec_mem.sv
`timescale 1ns/1ps
`include "fec_regs.svh"

// ----------------------------------------------------------------
// word store, registered read port
// ----------------------------------------------------------------
module fec_mem (
  input  wire logic                   mclk,
  input  wire logic                   we,
  input  wire logic [`FEC_ADDR_W-1:0] waddr,
  input  wire logic [`FEC_DATA_W-1:0] wdata,
  input  wire logic                   re,
  input  wire logic [`FEC_ADDR_W-1:0] raddr,
  output logic      [`FEC_DATA_W-1:0] rdata
);

  logic [`FEC_DATA_W-1:0] store [0:(1<<`FEC_ADDR_W)-1];

  // no reset on the array: contents are meaningless until written
  always_ff @(posedge mclk) begin
    if (we) begin
      store[waddr] <= wdata;
    end
    if (re) begin
      rdata <= store[raddr];
    end
  end

endmodule

// File: core/fec_pkg.sv
package fec_pkg;

  // synchronised pin: three stages plus the agreed level
  typedef struct packed {
    logic [2:0] stage;
    logic       level;
  } fec_sync_t;

  // wishbone answer side
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } fec_wb_out_t;

  // status pins toward the neighbours
  typedef struct packed {
    logic empty_flag_n;
    logic full_flag_n;
    logic output_ready_n;
    logic input_ready_n;
    logic almost_full_flag;
    logic almost_empty_flag;
    logic half_full_flag;
  } fec_flags_t;

  // whole state of the device
  typedef struct packed {
    fec_sync_t   mrst;
    fec_sync_t   ftsel;
    logic        fall_through_mode;
    logic [14:0] wptr;
    logic [14:0] rptr;
    logic [15:0] mem_cnt;
    logic        out_valid;
    logic        fetch_pend;
    logic [17:0] dout;
    fec_flags_t  flags;
    logic [15:0] full_ofs;
    logic [15:0] empty_ofs;
    fec_wb_out_t wb;
  } fec_state_t;

endpackage

// File: core/fec_regs.svh
`ifndef FEC_REGS_SVH
`define FEC_REGS_SVH

// ----------------------------------------------------------------
// storage geometry
// ----------------------------------------------------------------
`define FEC_DATA_W     18
`define FEC_ADDR_W     15
`define FEC_CNT_W      16
`define FEC_STD_DEPTH  16'h8000
`define FEC_HALF_DEPTH 16'h4000

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FEC_REG_FULL_OFS  8'h00
`define FEC_REG_EMPTY_OFS 8'h04
`define FEC_REG_STATUS    8'h08

// ----------------------------------------------------------------
// status field positions and reset values
// ----------------------------------------------------------------
`define FEC_ST_EMPTY_N  0
`define FEC_ST_FULL_N   1
`define FEC_ST_AFULL    2
`define FEC_ST_AEMPTY   3
`define FEC_ST_HALF     4
`define FEC_ST_MODE     5
`define FEC_ST_CNT_LSB  16
`define FEC_DEF_FULL_OFS  16'h007F
`define FEC_DEF_EMPTY_OFS 16'h007F

`endif

// File: core/fec_top.sv
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "fec_regs.svh"

module fec_top (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        master_reset_n,
  input  wire logic        fall_through_sel,
  input  wire logic        wr_tick,
  input  wire logic        rd_tick,
  input  wire logic        wr_en_n,
  input  wire logic        rd_en_n,
  input  wire logic [17:0] din,
  output logic      [17:0] dout,
  output logic             empty_flag_n,
  output logic             full_flag_n,
  output logic             output_ready_n,
  output logic             input_ready_n,
  output logic             almost_full_flag,
  output logic             almost_empty_flag,
  output logic             half_full_flag,
  output logic             fall_through_mode,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);

  fec_pkg::fec_state_t s;
  fec_pkg::fec_state_t next_s;

  logic                   mem_we;
  logic                   mem_re;
  logic [`FEC_DATA_W-1:0] mem_rdata;
  logic [15:0]            total;
  logic [15:0]            next_total;
  logic [15:0]            capacity;
  logic                   wr_ok;
  logic                   rd_ok;
  logic                   consume;
  logic [31:0]            status;
  logic                   wb_req;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  fec_mem u_mem (
    .mclk  (mclk),
    .we    (mem_we),
    .waddr (s.wptr),
    .wdata (din),
    .re    (mem_re),
    .raddr (s.rptr),
    .rdata (mem_rdata)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;

    // pin synchronisers: level moves only when stages two and three agree
    next_s.mrst.stage  = {s.mrst.stage[1:0], master_reset_n};
    next_s.ftsel.stage = {s.ftsel.stage[1:0], fall_through_sel};
    if (s.mrst.stage[1] == s.mrst.stage[2]) begin
      next_s.mrst.level = s.mrst.stage[2];
    end
    if (s.ftsel.stage[1] == s.ftsel.stage[2]) begin
      next_s.ftsel.level = s.ftsel.stage[2];
    end

    // the output register counts as one more slot in fall-through mode
    capacity = s.fall_through_mode ? `FEC_STD_DEPTH + 16'h0001 : `FEC_STD_DEPTH;
    total    = s.mem_cnt + {15'h0000, s.out_valid & s.fall_through_mode};

    // a word is taken on a write tick with wr_en_n low whenever the stored count is below capacity, whatever the flags show
    wr_ok = wr_tick & ~wr_en_n & (total < capacity);
    mem_we = wr_ok;

    // fall-through: a true read empties the output register
    consume = s.fall_through_mode & rd_tick & ~rd_en_n & s.out_valid;
    rd_ok = 1'b0;
    if (s.fall_through_mode) begin
      // refill the output register on free-running read ticks, no read needed
      rd_ok = rd_tick & (~s.out_valid | consume) & ~s.fetch_pend
              & (s.mem_cnt != 16'h0000);
    end else begin
      rd_ok = rd_tick & ~rd_en_n & ~s.fetch_pend & (s.mem_cnt != 16'h0000);
    end
    mem_re = rd_ok;

    if (wr_ok) begin
      next_s.wptr = s.wptr + 15'h0001;
    end
    if (rd_ok) begin
      next_s.rptr = s.rptr + 15'h0001;
    end
    next_s.mem_cnt = s.mem_cnt + {15'h0000, wr_ok} - {15'h0000, rd_ok};
    next_s.fetch_pend = rd_ok;

    // fetched word lands one cycle after the memory read
    if (consume) begin
      next_s.out_valid = 1'b0;
    end
    if (s.fetch_pend) begin
      next_s.dout      = mem_rdata;
      next_s.out_valid = 1'b1;
    end

    next_total = next_s.mem_cnt
               + {15'h0000, next_s.out_valid & s.fall_through_mode};

    // ready line follows the output register directly; empty line follows the stored count on read ticks
    if (s.fall_through_mode) begin
      next_s.flags.output_ready_n = ~next_s.out_valid;
      next_s.flags.empty_flag_n   = 1'b1;
    end else begin
      next_s.flags.output_ready_n = 1'b1;
      if (rd_tick) begin
        next_s.flags.empty_flag_n = (next_s.mem_cnt != 16'h0000);
      end
    end

    // write side flags: sampled on write ticks only, so a read shows late
    if (wr_tick) begin
      if (s.fall_through_mode) begin
        next_s.flags.input_ready_n = ~(next_total < capacity);
        next_s.flags.full_flag_n   = 1'b1;
      end else begin
        next_s.flags.input_ready_n = 1'b1;
        next_s.flags.full_flag_n   = (next_total < capacity);
      end
      next_s.flags.almost_full_flag = (next_total >= capacity - s.full_ofs);
    end

    // almost-empty on read ticks; fall-through adds one word of margin
    if (rd_tick) begin
      if (s.fall_through_mode) begin
        next_s.flags.almost_empty_flag = (next_total <= s.empty_ofs + 16'h0001);
      end else begin
        next_s.flags.almost_empty_flag = (next_total <= s.empty_ofs);
      end
    end

    // half-full reacts to either side at once
    next_s.flags.half_full_flag = (next_total > `FEC_HALF_DEPTH);

    // ----------------------------------------------------------------
    // wishbone slave: one wait state, unmapped reads return zero
    // ----------------------------------------------------------------
    status = 32'h0000_0000;
    status[`FEC_ST_EMPTY_N] = s.flags.empty_flag_n;
    status[`FEC_ST_FULL_N]  = s.flags.full_flag_n;
    status[`FEC_ST_AFULL]   = s.flags.almost_full_flag;
    status[`FEC_ST_AEMPTY]  = s.flags.almost_empty_flag;
    status[`FEC_ST_HALF]    = s.flags.half_full_flag;
    status[`FEC_ST_MODE]    = s.fall_through_mode;
    status[`FEC_ST_CNT_LSB +: 16] = total;

    wb_req = wb_cyc_i & wb_stb_i & ~s.wb.ack;
    next_s.wb.ack = wb_req;
    next_s.wb.dat = 32'h0000_0000;
    if (wb_req) begin
      case (wb_adr_i[7:0])
        `FEC_REG_FULL_OFS: begin
          next_s.wb.dat = {16'h0000, s.full_ofs};
          if (wb_we_i & wb_sel_i[0]) next_s.full_ofs[7:0] = wb_dat_i[7:0];
          if (wb_we_i & wb_sel_i[1]) next_s.full_ofs[15:8] = wb_dat_i[15:8];
        end
        `FEC_REG_EMPTY_OFS: begin
          next_s.wb.dat = {16'h0000, s.empty_ofs};
          if (wb_we_i & wb_sel_i[0]) next_s.empty_ofs[7:0] = wb_dat_i[7:0];
          if (wb_we_i & wb_sel_i[1]) next_s.empty_ofs[15:8] = wb_dat_i[15:8];
        end
        `FEC_REG_STATUS: begin
          next_s.wb.dat = status;
        end
        default: begin
          next_s.wb.dat = 32'h0000_0000;
        end
      endcase
      if (wb_we_i) begin
        next_s.wb.dat = 32'h0000_0000;
      end
    end

    // master reset empties the device and latches the timing mode;
    // offsets survive so software need not reload them
    if (~s.mrst.level) begin
      next_s.fall_through_mode = s.ftsel.level;
      next_s.wptr       = 15'h0000;
      next_s.rptr       = 15'h0000;
      next_s.mem_cnt    = 16'h0000;
      next_s.out_valid  = 1'b0;
      next_s.fetch_pend = 1'b0;
      next_s.dout       = 18'h00000;
      next_s.flags      = '{empty_flag_n: 1'b0, full_flag_n: 1'b1,
                            output_ready_n: 1'b1, input_ready_n: 1'b0,
                            almost_full_flag: 1'b0, almost_empty_flag: 1'b1,
                            half_full_flag: 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      s            <= '0;
      s.mrst       <= '{stage: 3'h7, level: 1'b1};
      s.ftsel      <= '{stage: 3'h0, level: 1'b0};
      s.flags      <= '{empty_flag_n: 1'b0, full_flag_n: 1'b1,
                        output_ready_n: 1'b1, input_ready_n: 1'b0,
                        almost_full_flag: 1'b0, almost_empty_flag: 1'b1,
                        half_full_flag: 1'b0};
      s.full_ofs   <= `FEC_DEF_FULL_OFS;
      s.empty_ofs  <= `FEC_DEF_EMPTY_OFS;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from state flip-flops
  // ----------------------------------------------------------------
  assign dout              = s.dout;
  assign empty_flag_n      = s.flags.empty_flag_n;
  assign full_flag_n       = s.flags.full_flag_n;
  assign output_ready_n    = s.flags.output_ready_n;
  assign input_ready_n     = s.flags.input_ready_n;
  assign almost_full_flag  = s.flags.almost_full_flag;
  assign almost_empty_flag = s.flags.almost_empty_flag;
  assign half_full_flag    = s.flags.half_full_flag;
  assign fall_through_mode = s.fall_through_mode;
  assign wb_dat_o          = s.wb.dat;
  assign wb_ack_o          = s.wb.ack;

endmodule

// File: test/fec_sink.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// downstream neighbour: takes the head word when it has room
// ----------------------------------------------------------------
module fec_sink (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic en,
  output logic      rd_en_n
);
  initial rd_en_n = 1'b1;
  // room comes and goes at random, so the device sees stalls mid-stream
  always @(posedge mclk) begin
    rd_en_n <= rst || !en || ($urandom_range(1, 0) == 0);
  end
endmodule

// File: test/fec_top_sva.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module fec_checker (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        master_reset_n,
  input wire logic        wr_tick,
  input wire logic        rd_tick,
  input wire logic        wr_en_n,
  input wire logic        rd_en_n,
  input wire logic        input_ready_n,
  input wire logic        output_ready_n,
  input wire logic        empty_flag_n,
  input wire logic        full_flag_n,
  input wire logic        almost_full_flag,
  input wire logic        almost_empty_flag,
  input wire logic        fall_through_mode,
  input wire logic [17:0] dout,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o
);
  logic [2:0] mr_cnt;
  // master reset acts behind a synchroniser, so checks rest a while after it
  always_ff @(posedge mclk) begin
    if (rst || !master_reset_n) begin
      mr_cnt <= 3'h7;
    end else if (mr_cnt != 3'h0) begin
      mr_cnt <= mr_cnt - 3'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || mr_cnt != 3'h0);

  a_afull_wr: assert property (!$stable(almost_full_flag) |-> $past(wr_tick))
    else $error("almost-full moved off a write tick");
  a_aempty_rd: assert property (!$stable(almost_empty_flag) |-> $past(rd_tick))
    else $error("almost-empty moved off a read tick");
  a_ir_wr_tick: assert property (!$stable(input_ready_n) |-> $past(wr_tick))
    else $error("input-ready moved off a write tick");
  a_or_true_read: assert property ($rose(output_ready_n) |-> $past(rd_tick && !rd_en_n))
    else $error("output ready dropped without a true read");
  a_word_holds: assert property (!output_ready_n && !(rd_tick && !rd_en_n)
    |=> !output_ready_n && $stable(dout))
    else $error("valid output word lost without a read");
  a_first_word: assert property (fall_through_mode && output_ready_n && wr_tick && !wr_en_n
    && !input_ready_n ##1 (rd_tick && rd_en_n) [*3] |-> !output_ready_n)
    else $error("first word late at the output");
  a_mode_flags: assert property (fall_through_mode ? (empty_flag_n && full_flag_n)
    : output_ready_n)
    else $error("flag of the other mode active");
  a_mode_hold: assert property ($stable(fall_through_mode))
    else $error("mode changed outside master reset");
  a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  a_wb_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("acknowledge without a request");
endmodule

bind fec_top fec_checker u_chk (.mclk, .rst, .master_reset_n, .wr_tick, .rd_tick, .wr_en_n,
  .rd_en_n, .input_ready_n, .output_ready_n, .empty_flag_n, .full_flag_n, .almost_full_flag,
  .almost_empty_flag, .fall_through_mode, .dout, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// File: test/fifo_expansion_chain_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module fifo_expansion_chain_bench;
  logic        mclk, rst, master_reset_n, fall_through_sel, wr_tick, rd_tick;
  logic        wr_en_n, rd_en_n, empty_flag_n, full_flag_n, output_ready_n, input_ready_n;
  logic        almost_full_flag, almost_empty_flag, half_full_flag, fall_through_mode;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sink_en, chk_en, t, w;
  logic [17:0] din, dout, d, e;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
  logic [3:0]  wb_sel_i;
  logic [17:0] q[$];
  int          err_count, n_tests, cyc, i;

  fec_top DUT (.mclk, .rst, .master_reset_n, .fall_through_sel, .wr_tick, .rd_tick,
    .wr_en_n, .rd_en_n, .din, .dout, .empty_flag_n, .full_flag_n, .output_ready_n,
    .input_ready_n, .almost_full_flag, .almost_empty_flag, .half_full_flag,
    .fall_through_mode, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o);
  fec_sink u_sink (.mclk, .rst, .en(sink_en), .rd_en_n);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // a hang would otherwise stall the run forever
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      finish_test();
    end
  end

  // every true read must hand over the oldest word still owed
  always @(posedge mclk) begin
    if (chk_en && rd_tick && !rd_en_n && output_ready_n === 1'b0) begin
      e = q.pop_front();
      `CHK(dout, e)
    end
  end

  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'h3;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // a slave that never answers ends the run at the single verdict
    if (n == 20) begin
      err_count++;
      finish_test();
    end
  endtask

  task automatic put(input logic [17:0] v);
    @(posedge mclk);
    wr_tick <= 1'b1;
    wr_en_n <= 1'b0;
    din     <= v;
    q.push_back(v);
  endtask

  task automatic idle(input int n);
    @(posedge mclk);
    wr_tick <= 1'b0;
    wr_en_n <= 1'b1;
    repeat (n) @(posedge mclk);
  endtask

  initial begin
    {rst, master_reset_n, fall_through_sel, wr_tick, rd_tick, wr_en_n, sink_en, chk_en} = 8'hE4;
    {wb_cyc_i, wb_stb_i, wb_we_i, din, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'h3;
    void'($urandom(32'h185029BF));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    wb(1'b0, 32'h0, 32'h0); `CHK(rd, 32'h7F)
    wb(1'b0, 32'h4, 32'h0); `CHK(rd, 32'h7F)
    wb(1'b0, 32'h10, 32'h0); `CHK(rd, 32'h0)
    // thresholds of three words make both flags move in a short stream
    wb(1'b1, 32'h0, 32'h7FFE);
    wb(1'b1, 32'h4, 32'h2);
    wb(1'b0, 32'h0, 32'h0); `CHK(rd, 32'h7FFE)
    // standard mode first: one word must lift the empty line, full stays idle
    rd_tick <= 1'b1;
    put(18'h15A5A);
    idle(4);
    `CHK(empty_flag_n, 1'b1)
    `CHK(full_flag_n, 1'b1)
    `CHK(input_ready_n, 1'b1)
    `CHK(almost_empty_flag, 1'b1)
    master_reset_n <= 1'b0;
    repeat (6) @(posedge mclk);
    master_reset_n <= 1'b1;
    rd_tick <= 1'b1;
    // master reset threw away the standard-mode word
    q.delete();
    repeat (8) @(posedge mclk);
    wb(1'b0, 32'h8, 32'h0); `CHK(rd[5], 1'b1)
    chk_en <= 1'b1;
    put(18'h2A5A5);
    idle(6);
    `CHK(output_ready_n, 1'b0)
    `CHK(dout, 18'h2A5A5)
    `CHK(almost_full_flag, 1'b0)
    for (i = 0; i < 4; i++) put(18'(i));
    idle(6);
    `CHK(almost_full_flag, 1'b1)
    `CHK(half_full_flag, 1'b0)
    `CHK(almost_empty_flag, 1'b0)
    `CHK(dout, 18'h2A5A5)
    // random ticks both sides while the sink stalls at random
    sink_en <= 1'b1;
    for (i = 0; i < 600; i++) begin
      @(posedge mclk);
      t = 1'($urandom_range(1, 0));
      w = (i < 300) && 1'($urandom_range(1, 0));
      d = 18'($urandom);
      wr_tick <= t;
      wr_en_n <= !w;
      din     <= d;
      rd_tick <= $urandom_range(3, 0) != 0;
      if (t && w) q.push_back(d);
    end
    `CHK(q.size(), 0)
    // let the last random drive settle before the ticks are driven again
    @(posedge mclk);
    wr_tick <= 1'b1;
    rd_tick <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(almost_full_flag, 1'b0)
    `CHK(almost_empty_flag, 1'b1)
    `CHK(output_ready_n, 1'b1)
    finish_test();
  end
endmodule
